// ==== scirq_pkg.sv ====
// Purpose: constants for the smart card interrupt mask and supply control
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register indexes are kept, byte address is four times the index
// Behaviour
// - An enable bit at 1 lets its flag raise the interrupt; 0 masks it.
// - A cleared enable bit only masks; the status flag still sets.
// - Enable bits 7 to 0 follow the status flag order, wait timeout first.
// - In synchronous mode bit 7 carries the receive length maximum event.
// - The enable register is at index FE02 and resets to all zero.
// - The supply register powers the card and picks 5, 3 or 1.8 V.
// - With the fault enable set, a core supply fault deactivates the card.
// - The supply register is at index FE03 and resets to all zero.
// - Reading the status register clears its clear-on-read flags.
// - A non-zero select written to bits 7 and 6 starts card activation when the power state is off and no fault trips.
package scirq_pkg;

    // ==========================================================
    // register indexes and byte addresses
    localparam logic [15:0] SCIRQ_IDX_STATUS = 16'hFE01;
    localparam logic [15:0] SCIRQ_IDX_ENABLE = 16'hFE02;
    localparam logic [15:0] SCIRQ_IDX_SUPPLY = 16'hFE03;
    localparam int SCIRQ_AW = 18;
    localparam logic [17:0] SCIRQ_ADDR_STATUS = {SCIRQ_IDX_STATUS, 2'h0};
    localparam logic [17:0] SCIRQ_ADDR_ENABLE = {SCIRQ_IDX_ENABLE, 2'h0};
    localparam logic [17:0] SCIRQ_ADDR_SUPPLY = {SCIRQ_IDX_SUPPLY, 2'h0};

    // ==========================================================
    // reset values
    localparam logic [7:0] SCIRQ_RST_STATUS = 8'h00;
    localparam logic [7:0] SCIRQ_RST_ENABLE = 8'h00;
    localparam logic [7:0] SCIRQ_RST_SUPPLY = 8'h00;

    // ==========================================================
    // status and enable bit positions
    localparam int SCIRQ_B_WAIT = 7;
    localparam int SCIRQ_B_CARD = 6;
    localparam int SCIRQ_B_TIMER = 5;
    localparam int SCIRQ_B_RXAV = 4;
    localparam int SCIRQ_B_TXEV = 3;
    localparam int SCIRQ_B_TXSENT = 2;
    localparam int SCIRQ_B_TXERR = 1;
    localparam int SCIRQ_B_RXERR = 0;
    localparam int SCIRQ_NSRC = 8;

    // ==========================================================
    // supply register fields
    localparam int SCIRQ_SEL_HI = 7;
    localparam int SCIRQ_SEL_LO = 6;
    localparam int SCIRQ_B_FAULT_EN = 5;
    localparam int SCIRQ_B_READY = 4;
    localparam int SCIRQ_B_GOOD = 3;
    localparam int SCIRQ_B_PWRDN = 0;
    localparam logic [1:0] SCIRQ_SEL_OFF = 2'h0;
    // writable bits: select, fault enable, power down
    localparam logic [7:0] SCIRQ_SUPPLY_WMASK = 8'hE1;

    // supply sequencer states
    typedef enum logic [1:0] {
        SCIRQ_PWR_OFF,
        SCIRQ_PWR_RAMP,
        SCIRQ_PWR_ON
    } scirq_pwr_t;

endpackage

// ==== scirq_sync.sv ====
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are slow levels from outside the pclk domain
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module scirq_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // ==========================================================
    // one pair of flops per bit
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r[gi] <= 1'b0;
                    sync_out[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= async_in[gi];
                    sync_out[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate
endmodule

// ==== scirq_gate.sv ====
// Purpose: masks status flags and merges them onto one interrupt line
// Assumes: flags and enables share the bit layout
// Notes: output registered so the core sees a glitch-free level
`timescale 1ns/1ps
module scirq_gate
    import scirq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // flags and enables
    input wire logic [SCIRQ_NSRC-1:0] flags,
    input wire logic [SCIRQ_NSRC-1:0] enables,
    // interrupt
    output logic irq
);
    logic [SCIRQ_NSRC-1:0] pending;

    // ==========================================================
    // per-source gating
    genvar gi;
    generate
        for (gi = 0; gi < SCIRQ_NSRC; gi = gi + 1) begin : g_src
            assign pending[gi] = flags[gi] & enables[gi];
        end
    endgenerate

    // or of all gated flags, every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |pending;
        end
    end
endmodule

// ==== scirq_top.sv ====
// Purpose: smart card interrupt enable, status and supply control registers
// Assumes: event inputs are one-cycle pulses from pclk logic
// Notes: supply ready, supply good and core fault arrive from pins
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module scirq_top
    import scirq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SCIRQ_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources
    input wire logic sync_mode,
    input wire logic wait_timeout_evt,
    input wire logic rx_len_max_evt,
    input wire logic card_event_evt,
    input wire logic supply_timer_evt,
    input wire logic rx_data_avail,
    input wire logic tx_event_evt,
    input wire logic tx_sent_evt,
    input wire logic tx_err_evt,
    input wire logic rx_err_evt,
    // supply pins
    input wire logic supply_ready_pin,
    input wire logic supply_good_pin,
    input wire logic core_fault_pin,
    // supply control outputs
    output logic [1:0] supply_voltage_select,
    output logic card_power_down,
    output logic activation_start,
    output logic card_deactivate,
    // interrupt to core
    output logic card_irq
);
    logic [7:0] card_irq_status_reg_r;
    logic [7:0] card_irq_enable_reg_r;
    logic [7:0] card_supply_ctl_reg_r;
    logic [7:0] status_nxt;
    logic [7:0] status_set;
    logic [7:0] status_clr;
    logic [7:0] rd_snap_r;
    logic [2:0] pin_s;
    logic supply_ready_state;
    logic supply_good_flag;
    logic fault_s;
    logic setup;
    logic access;
    logic hit_status;
    logic hit_enable;
    logic hit_supply;
    logic mapped;
    logic wr_enable;
    logic wr_supply;
    logic wr_status;
    logic rd_status;
    logic wait_src;
    logic fault_trip;
    logic [7:0] supply_wdata;
    scirq_pwr_t pwr_r;
    scirq_pwr_t pwr_nxt;

    // ==========================================================
    // pin synchronisers
    scirq_sync #(
        .WIDTH(3)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({core_fault_pin, supply_good_pin, supply_ready_pin}),
        .sync_out(pin_s)
    );

    assign supply_ready_state = pin_s[0];
    assign supply_good_flag = pin_s[1];
    assign fault_s = pin_s[2];

    // ==========================================================
    // apb decode; zero wait states, unmapped addresses give pslverr
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_status = (paddr == SCIRQ_ADDR_STATUS);
    assign hit_enable = (paddr == SCIRQ_ADDR_ENABLE);
    assign hit_supply = (paddr == SCIRQ_ADDR_SUPPLY);
    assign mapped = hit_status | hit_enable | hit_supply;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // writes only land when the low byte lane is strobed
    assign wr_enable = access & pwrite & pstrb[0] & hit_enable;
    assign wr_supply = access & pwrite & pstrb[0] & hit_supply;
    assign wr_status = access & pwrite & pstrb[0] & hit_status;
    assign rd_status = access & ~pwrite & hit_status;

    // ==========================================================
    // read data captured in setup so it is a flop during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_snap_r <= SCIRQ_RST_STATUS;
        end else if (setup & ~pwrite) begin
            if (hit_status) begin
                rd_snap_r <= card_irq_status_reg_r;
            end else if (hit_enable) begin
                rd_snap_r <= card_irq_enable_reg_r;
            end else if (hit_supply) begin
                rd_snap_r <= card_supply_ctl_reg_r;
            end else begin
                rd_snap_r <= 8'h00;
            end
        end
    end

    assign prdata = {24'h000000, rd_snap_r};

    // ==========================================================
    // enable register, all sources masked out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_irq_enable_reg_r <= SCIRQ_RST_ENABLE;
        end else if (wr_enable) begin
            card_irq_enable_reg_r <= pwdata[7:0];
        end
    end

    // ==========================================================
    // status flags; set wins over clear so no event is lost
    assign wait_src = sync_mode ? rx_len_max_evt : wait_timeout_evt;

    always_comb begin
        status_set = 8'h00;
        status_set[SCIRQ_B_WAIT] = wait_src;
        status_set[SCIRQ_B_CARD] = card_event_evt;
        status_set[SCIRQ_B_TIMER] = supply_timer_evt;
        status_set[SCIRQ_B_TXEV] = tx_event_evt;
        status_set[SCIRQ_B_TXSENT] = tx_sent_evt;
        status_set[SCIRQ_B_TXERR] = tx_err_evt;
        status_set[SCIRQ_B_RXERR] = rx_err_evt;
        // only clear what the read reported, later arrivals stay
        status_clr = 8'h00;
        if (rd_status) begin
            status_clr = rd_snap_r;
        end
        if (wr_status) begin
            status_clr = status_clr | pwdata[7:0];
        end
        // flags set regardless of the enable bits
        status_nxt = (card_irq_status_reg_r & ~status_clr) | status_set;
        // receive data flag follows the fifo level, not a clear
        status_nxt[SCIRQ_B_RXAV] = rx_data_avail;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_irq_status_reg_r <= SCIRQ_RST_STATUS;
        end else begin
            card_irq_status_reg_r <= status_nxt;
        end
    end

    // ==========================================================
    // interrupt merge
    scirq_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .flags(card_irq_status_reg_r),
        .enables(card_irq_enable_reg_r),
        .irq(card_irq)
    );

    // ==========================================================
    // supply control register; status bits mirror the pins
    assign fault_trip = card_supply_ctl_reg_r[SCIRQ_B_FAULT_EN] & fault_s;
    assign supply_wdata = pwdata[7:0] & SCIRQ_SUPPLY_WMASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_supply_ctl_reg_r <= SCIRQ_RST_SUPPLY;
        end else begin
            if (fault_trip) begin
                // emergency: drop the select to zero volts
                card_supply_ctl_reg_r[SCIRQ_SEL_HI:SCIRQ_SEL_LO] <=
                    SCIRQ_SEL_OFF;
            end else if (wr_supply) begin
                // both select bits taken from one write
                card_supply_ctl_reg_r[SCIRQ_SEL_HI:SCIRQ_SEL_LO] <=
                    supply_wdata[SCIRQ_SEL_HI:SCIRQ_SEL_LO];
            end
            if (wr_supply) begin
                card_supply_ctl_reg_r[SCIRQ_B_FAULT_EN] <=
                    supply_wdata[SCIRQ_B_FAULT_EN];
                card_supply_ctl_reg_r[SCIRQ_B_PWRDN] <=
                    supply_wdata[SCIRQ_B_PWRDN];
            end
            card_supply_ctl_reg_r[SCIRQ_B_READY] <= supply_ready_state;
            card_supply_ctl_reg_r[SCIRQ_B_GOOD] <= supply_good_flag;
        end
    end

    assign supply_voltage_select =
        card_supply_ctl_reg_r[SCIRQ_SEL_HI:SCIRQ_SEL_LO];
    assign card_power_down = card_supply_ctl_reg_r[SCIRQ_B_PWRDN];

    // ==========================================================
    // coarse power state, drives activation and deactivation pulses
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            SCIRQ_PWR_OFF: begin
                if (wr_supply & ~fault_trip &
                    (supply_wdata[SCIRQ_SEL_HI:SCIRQ_SEL_LO] !=
                     SCIRQ_SEL_OFF)) begin
                    pwr_nxt = SCIRQ_PWR_RAMP;
                end
            end
            SCIRQ_PWR_RAMP: begin
                if (fault_trip || supply_voltage_select == SCIRQ_SEL_OFF) begin
                    pwr_nxt = SCIRQ_PWR_OFF;
                end else if (supply_ready_state) begin
                    pwr_nxt = SCIRQ_PWR_ON;
                end
            end
            SCIRQ_PWR_ON: begin
                if (fault_trip || supply_voltage_select == SCIRQ_SEL_OFF) begin
                    pwr_nxt = SCIRQ_PWR_OFF;
                end
            end
            default: begin
                pwr_nxt = SCIRQ_PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_r <= SCIRQ_PWR_OFF;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // pulses registered so downstream sequencing sees clean edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            activation_start <= 1'b0;
            card_deactivate <= 1'b0;
        end else begin
            activation_start <= (pwr_r == SCIRQ_PWR_OFF) &
                                (pwr_nxt == SCIRQ_PWR_RAMP);
            card_deactivate <= (pwr_r != SCIRQ_PWR_OFF) &
                               (pwr_nxt == SCIRQ_PWR_OFF);
        end
    end

    // ==========================================================
    // assertions
    property p_irq_mask;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> card_irq == $past(|(card_irq_status_reg_r &
                                     card_irq_enable_reg_r));
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt does not follow gated flags");

    property p_masked_sets;
        @(posedge pclk) disable iff (!presetn)
        card_event_evt && !card_irq_enable_reg_r[SCIRQ_B_CARD]
            |=> card_irq_status_reg_r[SCIRQ_B_CARD];
    endproperty
    a_masked_sets: assert property (p_masked_sets)
        else $error("masked flag failed to set");

    property p_enable_write;
        @(posedge pclk) disable iff (!presetn)
        wr_enable |=> card_irq_enable_reg_r == $past(pwdata[7:0]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable register did not take write");

    property p_sync_len;
        @(posedge pclk) disable iff (!presetn)
        sync_mode && rx_len_max_evt |=> card_irq_status_reg_r[SCIRQ_B_WAIT];
    endproperty
    a_sync_len: assert property (p_sync_len)
        else $error("length maximum event not flagged in sync mode");

    property p_sync_no_wait;
        @(posedge pclk) disable iff (!presetn)
        sync_mode && wait_timeout_evt && !rx_len_max_evt &&
        !card_irq_status_reg_r[SCIRQ_B_WAIT]
            |=> !card_irq_status_reg_r[SCIRQ_B_WAIT];
    endproperty
    a_sync_no_wait: assert property (p_sync_no_wait)
        else $error("wait timeout flagged in sync mode");

    property p_fault_deact;
        @(posedge pclk) disable iff (!presetn)
        fault_trip |=> supply_voltage_select == SCIRQ_SEL_OFF;
    endproperty
    a_fault_deact: assert property (p_fault_deact)
        else $error("fault did not drop the supply select");

    property p_activate;
        @(posedge pclk) disable iff (!presetn)
        pwr_r == SCIRQ_PWR_OFF && wr_supply && !fault_trip &&
        supply_wdata[SCIRQ_SEL_HI:SCIRQ_SEL_LO] != SCIRQ_SEL_OFF
            |=> activation_start ##1 !activation_start;
    endproperty
    a_activate: assert property (p_activate)
        else $error("activation did not start on non-zero select");

    property p_read_clear;
        @(posedge pclk) disable iff (!presetn)
        rd_status && rd_snap_r[SCIRQ_B_TIMER] && !supply_timer_evt
            |=> !card_irq_status_reg_r[SCIRQ_B_TIMER];
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read did not clear the flag");

    property p_rxav_level;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> card_irq_status_reg_r[SCIRQ_B_RXAV] == $past(rx_data_avail);
    endproperty
    a_rxav_level: assert property (p_rxav_level)
        else $error("receive data flag does not track level");
endmodule

// ==== scirq_src_model.sv ====
// Purpose: event source standing in for the card uart and supply logic
// Assumes: requests change right after a rising edge of pclk
// Notes: outputs are registered, so each pulse is one clean cycle
`timescale 1ns/1ps
module scirq_src_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // requests from the bench, bit 8 is the length maximum
    input wire logic [8:0] req,
    // events toward the design
    output logic [8:0] evt
);
    // ==========================================================
    // event launch
    // registered so no event moves on the design's sampling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= 9'h000;
        end else begin
            evt <= req;
        end
    end
endmodule

// ==== tb_smart_card_irq_mask_and_supply_ctl.sv ====
// Purpose: register level test of interrupt masking and supply control
// Assumes: zero wait apb slave, event pulses from the source model
// Notes: status bit 4 is a level, so it is held rather than pulsed
`timescale 1ns/1ps
module tb_smart_card_irq_mask_and_supply_ctl;
    import scirq_pkg::*;
    // ==========================================================
    // signals
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [SCIRQ_AW-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sync_mode = 1'h0;
    logic [8:0] req = 9'h000;
    logic [8:0] evt;
    logic rdy_pin = 1'h0;
    logic good_pin = 1'h0;
    logic fault_pin = 1'h0;
    logic [1:0] vsel;
    logic pwr_dn;
    logic act;
    logic deact;
    logic card_irq;
    logic [31:0] rd;
    logic err;
    logic hit;
    int fails = 0;
    int checks_done = 0;

    // ==========================================================
    // clock, source model and design
    initial begin
        forever #25 pclk = ~pclk;
    end
    scirq_src_model i_src (.pclk(pclk), .presetn(presetn), .req(req),
        .evt(evt));
    scirq_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_mode(sync_mode), .wait_timeout_evt(evt[7]),
        .rx_len_max_evt(evt[8]), .card_event_evt(evt[6]),
        .supply_timer_evt(evt[5]), .rx_data_avail(evt[4]),
        .tx_event_evt(evt[3]), .tx_sent_evt(evt[2]), .tx_err_evt(evt[1]),
        .rx_err_evt(evt[0]), .supply_ready_pin(rdy_pin),
        .supply_good_pin(good_pin), .core_fault_pin(fault_pin),
        .supply_voltage_select(vsel), .card_power_down(pwr_dn),
        .activation_start(act), .card_deactivate(deact),
        .card_irq(card_irq));

    // ==========================================================
    // verdict and compares
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task check1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: bit %b want %b", $time, got, exp);
        end
    endtask

    // ==========================================================
    // apb master: hold everything until pready is seen high
    task apb(input logic w, input logic [SCIRQ_AW-1:0] a,
             input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            fails++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // bounded watch for a pulse or level: 0 start, 1 deact, 2 irq
    task wait_for(input int sel);
        hit = 1'h0;
        repeat (8) begin
            @(posedge pclk);
            if ((sel == 0 && act === 1'h1) || (sel == 1 && deact === 1'h1)
                || (sel == 2 && card_irq === 1'h1))
                hit = 1'h1;
        end
    endtask
    task fire(input logic [8:0] v);
        @(posedge pclk);
        req <= v;
        @(posedge pclk);
        req <= 9'h000;
    endtask

    // ==========================================================
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, SCIRQ_ADDR_ENABLE, 8'h00);
        check8(rd[7:0], 8'h00);
        apb(1'h0, SCIRQ_ADDR_SUPPLY, 8'h00);
        check8(rd[7:0], 8'h00);
        check1(card_irq, 1'h0);
        apb(1'h1, SCIRQ_ADDR_ENABLE, 8'hA5);
        pstrb <= 4'h0;
        apb(1'h1, SCIRQ_ADDR_ENABLE, 8'h00);
        pstrb <= 4'hF;
        apb(1'h0, SCIRQ_ADDR_ENABLE, 8'h00);
        check8(rd[7:0], 8'hA5);
        apb(1'h0, 18'h00000, 8'h00);
        check1(err, 1'h1);
        check8(rd[7:0], 8'h00);
        $display("reset and access test done");
        // every source: flag sets while masked, irq only once enabled
        for (int i = 0; i < 8; i++) begin
            apb(1'h1, SCIRQ_ADDR_ENABLE, 8'h00);
            if (i == 4) begin
                @(posedge pclk);
                req <= 9'h010;
            end else begin
                fire(9'h001 << i);
            end
            repeat (6) @(posedge pclk);
            check1(card_irq, 1'h0);
            apb(1'h1, SCIRQ_ADDR_ENABLE, 8'h01 << i);
            wait_for(2);
            check1(hit, 1'h1);
            apb(1'h0, SCIRQ_ADDR_STATUS, 8'h00);
            check8(rd[7:0], 8'h01 << i);
            req <= 9'h000;
            repeat (3) @(posedge pclk);
            apb(1'h0, SCIRQ_ADDR_STATUS, 8'h00);
            check8(rd[7:0], 8'h00);
            repeat (3) @(posedge pclk);
            check1(card_irq, 1'h0);
        end
        $display("source mask test done");
        // synchronous mode swaps the bit 7 source
        sync_mode <= 1'h1;
        apb(1'h1, SCIRQ_ADDR_ENABLE, 8'h80);
        fire(9'h080);
        repeat (6) @(posedge pclk);
        check1(card_irq, 1'h0);
        fire(9'h100);
        wait_for(2);
        check1(hit, 1'h1);
        apb(1'h0, SCIRQ_ADDR_STATUS, 8'h00);
        check8(rd[7:0], 8'h80);
        sync_mode <= 1'h0;
        $display("sync mode test done");
        // supply: both select bits in one write, then a core fault
        apb(1'h1, SCIRQ_ADDR_SUPPLY, 8'hA0);
        wait_for(0);
        check1(hit, 1'h1);
        check8({6'h00, vsel}, 8'h02);
        apb(1'h1, SCIRQ_ADDR_SUPPLY, 8'hA1);
        @(posedge pclk);
        check1(pwr_dn, 1'h1);
        rdy_pin <= 1'h1;
        good_pin <= 1'h1;
        repeat (4) @(posedge pclk);
        apb(1'h0, SCIRQ_ADDR_SUPPLY, 8'h00);
        check8(rd[7:0], 8'hB9);
        fault_pin <= 1'h1;
        wait_for(1);
        check1(hit, 1'h1);
        check8({6'h00, vsel}, 8'h00);
        fault_pin <= 1'h0;
        $display("supply test done");
        give_verdict();
    end
endmodule
